// *** chan_byte_fifo.sv ***
// chan_byte_fifo.sv: byte fifo of the channel, pushes and pops one to four bytes
// assumes the caller never overfills or overdrains it
`timescale 1ns/1ps
module chan_byte_fifo #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          clr,
  input  wire logic          push,
  input  wire logic [2:0]    push_n,
  input  wire logic [31:0]   push_data,
  input  wire logic          pop,
  input  wire logic [2:0]    pop_n,
  output logic      [31:0]   peek,
  output logic      [AW:0]   count
);
  logic [7:0]    mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;

  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (push && (3'(i) < push_n)) begin
        mem_q[wr_q + AW'(i)] <= push_data[8*i +: 8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(push_n);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(pop_n);
      end
      cnt_q <= cnt_q + (push ? (AW+1)'(push_n) : '0) - (pop ? (AW+1)'(pop_n) : '0);
    end
  end

  genvar g;
  for (g = 0; g < 4; g++) begin : g_peek
    assign peek[8*g +: 8] = mem_q[rd_q + AW'(g)];
  end
  assign count = cnt_q;
endmodule

// *** dma_chan.sv ***
// dma_chan.sv: one dma channel with list fetch, writeback, suspend, abort and write protection
// assumes an ahb-lite register master, an ahb-lite memory slave, one clock hclk
// Function
// - fetch five item words, destination word ignored
// - write back only control a, same place
// - done bit set in written-back word
// - fetch next item at once, destination untouched
// - end of buffer checks final setting
// - final buffer raises chain flag, disables channel
// - enable starts channel, hardware clears it
// - suspend stops source reads, destination drains
// - empty flag when no destination word fits
// - resume bit leaves suspension, runs to end
// - disable only requests stop, status stays
// - disable discards fifo contents
// - disable may leave source handshake unacknowledged
// - write protection blocks writes to gcfg, en and saddr through cfg, records violation
// - reading protection status clears violation
// - zero size with controller flow disables
// - auto mode reloads size, fetch keeps it
`timescale 1ns/1ps
`include "dma_chan_map.svh"
module dma_chan
  import dma_chan_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW    = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic      [31:0] m_haddr,
  output logic      [1:0]  m_htrans,
  output logic             m_hwrite,
  output logic      [2:0]  m_hsize,
  output logic      [31:0] m_hwdata,
  input  wire logic [31:0] m_hrdata,
  input  wire logic        m_hready,
  input  wire logic        src_req,
  output logic             src_ack
);
  logic [11:0]        addr_q;
  logic               wr_pend_q;
  logic               rd_pend_q;
  logic               hreadyout_q;
  logic [31:0]        hrdata_q;
  logic [31:0]        rd_mux;
  logic [31:0]        gcfg_q;
  logic               glob_en_q;
  logic               wprot_on;
  logic               wprot_violation;
  logic [15:0]        wprot_violation_src;
  logic [31:0]        source_addr_reg;
  logic [31:0]        dest_addr_reg;
  logic [31:0]        descriptor_pointer;
  logic [31:0]        control_a_reg;
  logic [31:0]        control_b_reg;
  logic [31:0]        cfg_q;
  logic [31:0]        lli_q;
  logic               en_q;
  logic               susp_q;
  logic               term_q;
  logic               btc_q;
  logic               cbtc_q;
  logic               list_q;
  logic               dph_q;
  logic               op_src_q;
  logic               fclr_q;
  logic               src_ack_q;
  logic [2:0]         idx_q;
  logic [15:0]        rem_q;
  chan_state_e        state_q;
  logic [31:0]        m_haddr_q;
  logic [31:0]        m_hwdata_q;
  logic [1:0]         m_htrans_q;
  logic               m_hwrite_q;
  logic [2:0]         m_hsize_q;
  logic [31:0]        peek;
  logic [FIFO_AW:0]   fcnt;
  logic [FIFO_AW:0]   fspace;
  xfer_width_t        src_w;
  xfer_width_t        dst_w;
  logic [2:0]         src_n;
  logic [2:0]         dst_n;
  logic [15:0]        size_f;
  logic               wr_prot;
  logic               wr_ok;
  logic               wr_cher;
  logic               wr_chdr;
  logic               idle_bus;
  logic               issue;
  logic               can_src;
  logic               can_dst;
  logic               final_buf;
  logic               fifo_empty_flag;
  logic               done_ph;
  logic               push;
  logic               pop;

  assign src_w           = control_a_reg[`CA_SRCW_LSB +: 2];
  assign dst_w           = control_a_reg[`CA_DSTW_LSB +: 2];
  assign src_n           = 3'd1 << src_w;
  assign dst_n           = 3'd1 << dst_w;
  assign size_f          = control_a_reg[`CA_SIZE_LSB +: `CA_SIZE_W];
  assign fspace          = (FIFO_AW+1)'(FIFO_DEPTH) - fcnt;
  assign wr_prot         = wprot_on && (addr_q == `OFF_GCFG || addr_q == `OFF_EN ||
                           (addr_q >= `OFF_SADDR && addr_q <= `OFF_CFG));
  assign wr_ok           = wr_pend_q && !wr_prot;
  assign wr_cher         = wr_ok && addr_q == `OFF_CHER;
  assign wr_chdr         = wr_ok && addr_q == `OFF_CHDR;
  assign idle_bus        = !dph_q && m_htrans_q == `HT_IDLE;
  assign issue           = state_q == ST_RUN && idle_bus && !term_q;
  assign final_buf       = descriptor_pointer == 32'h0 && !control_b_reg[`CB_AUTO_BIT];
  assign can_dst         = fcnt >= (FIFO_AW+1)'(dst_n);
  assign can_src         = rem_q != 16'h0 && !susp_q && fspace >= (FIFO_AW+1)'(src_n) &&
                           (!cfg_q[`CFG_SRCHW_BIT] || src_req);
  assign fifo_empty_flag = fcnt < (FIFO_AW+1)'(dst_n);
  assign done_ph         = dph_q && m_hready;
  assign push            = state_q == ST_RUN && done_ph && op_src_q;
  assign pop             = issue && can_dst;

  chan_byte_fifo #(
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clr       (fclr_q),
    .push      (push),
    .push_n    (src_n),
    .push_data (m_hrdata >> {source_addr_reg[1:0], 3'b000}),
    .pop       (pop),
    .pop_n     (dst_n),
    .peek      (peek),
    .count     (fcnt)
  );

  always_comb begin
    rd_mux = 32'h0;
    case (addr_q)
      `OFF_GCFG:  rd_mux = gcfg_q;
      `OFF_EN:    rd_mux = {31'h0, glob_en_q};
      `OFF_STAT:  rd_mux = {30'h0, cbtc_q, btc_q};
      `OFF_CHSR:  rd_mux = {15'h0, fifo_empty_flag, 7'h0, susp_q, 7'h0, en_q};
      `OFF_SADDR: rd_mux = source_addr_reg;
      `OFF_DADDR: rd_mux = dest_addr_reg;
      `OFF_DSCR:  rd_mux = descriptor_pointer;
      `OFF_CTRLA: rd_mux = control_a_reg;
      `OFF_CTRLB: rd_mux = control_b_reg;
      `OFF_CFG:   rd_mux = cfg_q;
      `OFF_WPMR:  rd_mux = {31'h0, wprot_on};
      `OFF_WPSR:  rd_mux = {8'h0, wprot_violation_src, 7'h0, wprot_violation};
      default:    rd_mux = 32'h0;
    endcase
  end

  // register slave: writes zero wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q      <= 12'h0;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0;
    end else if (hsel && hready && htrans[1]) begin
      addr_q      <= haddr[11:0];
      wr_pend_q   <= hwrite;
      rd_pend_q   <= !hwrite;
      hreadyout_q <= hwrite;
    end else begin
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q   <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q    <= rd_mux;
      end
    end
  end

  // global registers and write protection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gcfg_q              <= `RST_GCFG;
      glob_en_q           <= 1'b0;
      wprot_on            <= 1'b0;
      wprot_violation     <= 1'b0;
      wprot_violation_src <= 16'h0;
    end else begin
      if (wr_ok && addr_q == `OFF_GCFG) begin
        gcfg_q <= hwdata;
      end
      if (wr_ok && addr_q == `OFF_EN) begin
        glob_en_q <= hwdata[0];
      end
      if (wr_ok && addr_q == `OFF_WPMR) begin
        wprot_on <= hwdata[0];
      end
      if (rd_pend_q && addr_q == `OFF_WPSR) begin
        wprot_violation <= 1'b0;
      end
      if (wr_pend_q && wr_prot) begin
        wprot_violation     <= 1'b1;
        wprot_violation_src <= {4'h0, addr_q};
      end
    end
  end

  // channel registers, sequencer and memory master
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_addr_reg    <= 32'h0;
      dest_addr_reg      <= 32'h0;
      descriptor_pointer <= 32'h0;
      control_a_reg      <= 32'h0;
      control_b_reg      <= 32'h0;
      cfg_q              <= `RST_CFG;
      lli_q              <= 32'h0;
      en_q               <= 1'b0;
      susp_q             <= 1'b0;
      term_q             <= 1'b0;
      btc_q              <= 1'b0;
      cbtc_q             <= 1'b0;
      list_q             <= 1'b0;
      dph_q              <= 1'b0;
      op_src_q           <= 1'b0;
      fclr_q             <= 1'b0;
      src_ack_q          <= 1'b0;
      idx_q              <= 3'h0;
      rem_q              <= 16'h0;
      state_q            <= ST_IDLE;
      m_haddr_q          <= 32'h0;
      m_hwdata_q         <= 32'h0;
      m_htrans_q         <= `HT_IDLE;
      m_hwrite_q         <= 1'b0;
      m_hsize_q          <= 3'h2;
    end else begin
      src_ack_q <= 1'b0;
      fclr_q    <= 1'b0;
      if (m_htrans_q == `HT_NONSEQ && m_hready) begin
        m_htrans_q <= `HT_IDLE;
        dph_q      <= 1'b1;
      end
      if (done_ph) begin
        dph_q <= 1'b0;
      end
      if (rd_pend_q && addr_q == `OFF_STAT) begin
        btc_q  <= 1'b0;
        cbtc_q <= 1'b0;
      end
      if (wr_ok) begin
        case (addr_q)
          `OFF_SADDR: source_addr_reg    <= hwdata;
          `OFF_DADDR: dest_addr_reg      <= hwdata;
          `OFF_DSCR:  descriptor_pointer <= hwdata;
          `OFF_CTRLA: control_a_reg      <= hwdata;
          `OFF_CTRLB: control_b_reg      <= hwdata;
          `OFF_CFG:   cfg_q              <= hwdata;
          default:    ;
        endcase
      end
      if (wr_cher && hwdata[`CH_SUSP_BIT] && en_q) begin
        susp_q <= 1'b1;
      end
      if (wr_chdr && hwdata[`CH_SUSP_BIT]) begin
        susp_q <= 1'b0;
      end
      if (en_q && ((wr_chdr && hwdata[`CH_EN_BIT]) ||
                   (wr_ok && addr_q == `OFF_EN && !hwdata[0]))) begin
        term_q <= 1'b1;
      end
      if (term_q && idle_bus) begin
        state_q <= ST_IDLE;
        en_q    <= 1'b0;
        term_q  <= 1'b0;
        susp_q  <= 1'b0;
        fclr_q  <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (wr_cher && hwdata[`CH_EN_BIT] && glob_en_q) begin
              if (!control_b_reg[`CB_NODSCR_BIT]) begin
                lli_q   <= descriptor_pointer;
                idx_q   <= 3'h0;
                list_q  <= 1'b1;
                en_q    <= 1'b1;
                state_q <= ST_FETCH;
              end else if (control_b_reg[`CB_FC_BIT] || size_f != 16'h0) begin
                rem_q   <= size_f;
                list_q  <= 1'b0;
                en_q    <= 1'b1;
                state_q <= ST_RUN;
              end
            end
          end
          ST_FETCH: begin
            if (idle_bus && !term_q) begin
              m_htrans_q <= `HT_NONSEQ;
              m_haddr_q  <= lli_q + {27'h0, idx_q, 2'b00};
              m_hwrite_q <= 1'b0;
              m_hsize_q  <= 3'h2;
            end
            if (done_ph) begin
              case (idx_q)
                3'h0: source_addr_reg    <= m_hrdata;
                3'h2: descriptor_pointer <= m_hrdata;
                3'h3: control_a_reg      <= control_b_reg[`CB_AUTO_BIT] ?
                        {m_hrdata[31:16], control_a_reg[15:0]} : m_hrdata;
                3'h4: control_b_reg      <= m_hrdata;
                default: ;
              endcase
              idx_q <= idx_q + 3'h1;
              if (idx_q == `LLI_LAST_IDX) begin
                rem_q   <= size_f;
                state_q <= ST_RUN;
                if (!m_hrdata[`CB_FC_BIT] && size_f == 16'h0) begin
                  state_q <= ST_IDLE;
                  en_q    <= 1'b0;
                end
              end
            end
          end
          ST_RUN: begin
            if (issue && can_dst) begin
              m_htrans_q <= `HT_NONSEQ;
              m_haddr_q  <= dest_addr_reg;
              m_hwrite_q <= 1'b1;
              m_hsize_q  <= {1'b0, dst_w};
              m_hwdata_q <= peek << {dest_addr_reg[1:0], 3'b000};
              op_src_q   <= 1'b0;
            end else if (issue && can_src) begin
              m_htrans_q <= `HT_NONSEQ;
              m_haddr_q  <= source_addr_reg;
              m_hwrite_q <= 1'b0;
              m_hsize_q  <= {1'b0, src_w};
              op_src_q   <= 1'b1;
            end else if (issue && rem_q == 16'h0) begin
              control_a_reg[`CA_DONE_BIT] <= 1'b1;
              btc_q  <= 1'b1;
              fclr_q <= 1'b1;
              idx_q  <= 3'h0;
              if (list_q) begin
                state_q <= ST_WBACK;
              end else if (final_buf) begin
                cbtc_q  <= 1'b1;
                en_q    <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                rem_q <= size_f;
              end
            end
            if (done_ph && op_src_q) begin
              source_addr_reg <= source_addr_reg + {29'h0, src_n};
              rem_q           <= rem_q - 16'h1;
              src_ack_q       <= cfg_q[`CFG_SRCHW_BIT] && !term_q;
            end else if (done_ph) begin
              dest_addr_reg <= dest_addr_reg + {29'h0, dst_n};
            end
          end
          ST_WBACK: begin
            if (idle_bus && !term_q && idx_q == 3'h0) begin
              m_htrans_q <= `HT_NONSEQ;
              m_haddr_q  <= lli_q + `LLI_CTRLA_OFF;
              m_hwrite_q <= 1'b1;
              m_hsize_q  <= 3'h2;
              m_hwdata_q <= control_a_reg;
              idx_q      <= 3'h1;
            end
            if (done_ph) begin
              idx_q <= 3'h0;
              if (final_buf) begin
                cbtc_q  <= 1'b1;
                btc_q   <= 1'b1;
                en_q    <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                lli_q   <= descriptor_pointer;
                state_q <= ST_FETCH;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;
  assign m_haddr   = m_haddr_q;
  assign m_htrans  = m_htrans_q;
  assign m_hwrite  = m_hwrite_q;
  assign m_hsize   = m_hsize_q;
  assign m_hwdata  = m_hwdata_q;
  assign src_ack   = src_ack_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_fetch_keeps_dest: assert property (
    state_q == ST_FETCH |=> dest_addr_reg == $past(dest_addr_reg) || $past(wr_ok))
    else $error("destination address changed during list fetch");
  a_wback_target: assert property (
    state_q == ST_WBACK && $rose(m_htrans_q == `HT_NONSEQ) |->
      m_hwrite_q && m_haddr_q == lli_q + `LLI_CTRLA_OFF)
    else $error("writeback not aimed at item control word");
  a_wback_done_bit: assert property (
    state_q == ST_WBACK && dph_q |-> m_hwdata_q[`CA_DONE_BIT])
    else $error("writeback lacks done bit");
  a_final_disables: assert property (
    $rose(cbtc_q) |-> !en_q && btc_q && state_q == ST_IDLE)
    else $error("chain completion without disable");
  a_suspend_no_src: assert property (
    $rose(m_htrans_q == `HT_NONSEQ) && state_q == ST_RUN && op_src_q |-> !$past(susp_q))
    else $error("source read issued while suspended");
  a_discard_on_stop: assert property (
    $fell(en_q) |=> fcnt == '0)
    else $error("fifo not emptied on stop");
  a_term_status: assert property (
    term_q && !idle_bus && !done_ph |=> en_q)
    else $error("status dropped before bus quiet");
  a_wprot_blocks: assert property (
    wr_pend_q && wprot_on && addr_q == `OFF_GCFG |=> $stable(gcfg_q) && wprot_violation)
    else $error("protected write not blocked");
  a_wpsr_clears: assert property (
    rd_pend_q && addr_q == `OFF_WPSR |=> !wprot_violation)
    else $error("status read did not clear violation");
  a_zero_size: assert property (
    state_q == ST_IDLE && wr_cher && hwdata[`CH_EN_BIT] && control_b_reg[`CB_NODSCR_BIT] &&
      !control_b_reg[`CB_FC_BIT] && size_f == 16'h0 |=> !en_q)
    else $error("zero size channel started");

  c_chain_done: cover property ($rose(cbtc_q));
  c_suspended: cover property (susp_q && fifo_empty_flag && en_q);
  c_violation: cover property ($rose(wprot_violation));
  c_writeback: cover property (state_q == ST_WBACK ##[1:20] state_q == ST_FETCH);
endmodule

// *** dma_chan_map.svh ***
// dma_chan_map.svh: register offsets, field positions and reset values of the dma channel
// assumes inclusion by every file that decodes channel registers
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH
`define OFF_GCFG      12'h000
`define OFF_EN        12'h004
`define OFF_STAT      12'h024
`define OFF_CHER      12'h028
`define OFF_CHDR      12'h02c
`define OFF_CHSR      12'h030
`define OFF_SADDR     12'h03c
`define OFF_DADDR     12'h040
`define OFF_DSCR      12'h044
`define OFF_CTRLA     12'h048
`define OFF_CTRLB     12'h04c
`define OFF_CFG       12'h050
`define OFF_WPMR      12'h1e4
`define OFF_WPSR      12'h1e8
`define RST_GCFG      32'h0000_0010
`define RST_CFG       32'h0100_0000
`define CA_SIZE_LSB   0
`define CA_SIZE_W     16
`define CA_SRCW_LSB   24
`define CA_DSTW_LSB   28
`define CA_DONE_BIT   31
`define CB_NODSCR_BIT 16
`define CB_FC_BIT     21
`define CB_AUTO_BIT   31
`define CFG_SRCHW_BIT 9
`define CH_EN_BIT     0
`define CH_SUSP_BIT   8
`define CH_EMPTY_BIT  16
`define WPSR_SRC_LSB  8
`define HT_IDLE       2'b00
`define HT_NONSEQ     2'b10
`define LLI_CTRLA_OFF 32'h0000_000c
`define LLI_LAST_IDX  3'h4
`endif

// *** dma_chan_pkg.sv ***
// dma_chan_pkg.sv: types shared by the dma channel files
// assumes no other package
package dma_chan_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_WBACK = 4'b1000
  } chan_state_e;
  typedef logic [1:0] xfer_width_t;
endpackage

// *** dma_mem_model.sv ***
// dma_mem_model.sv: ahb-lite memory slave and source peripheral facing the dma channel
// assumes one outstanding transfer at a time, word accesses within 1 kbyte
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic        hclk,
  input  wire logic        slow,
  input  wire logic [31:0] m_haddr,
  input  wire logic [1:0]  m_htrans,
  input  wire logic        m_hwrite,
  input  wire logic [31:0] m_hwdata,
  output logic      [31:0] m_hrdata,
  output logic             m_hready,
  output logic             src_req
);
  logic [31:0] mem [0:255];
  logic [7:0]  a_q  = 8'h00;
  logic        w_q  = 1'b0;
  logic        ph_q = 1'b0;
  logic        tg_q = 1'b0;
  // slow mode stalls every other cycle
  assign m_hready = !slow || tg_q;
  // read data only in a read data phase, inverted otherwise
  assign m_hrdata = (ph_q && !w_q) ? mem[a_q] : ~mem[a_q];
  // request always up, acknowledge never awaited
  assign src_req  = 1'b1;
  always @(posedge hclk) begin
    tg_q <= !tg_q;
    if (m_hready) begin
      if (ph_q && w_q) mem[a_q] <= m_hwdata;
      ph_q <= m_htrans[1];
      a_q  <= m_haddr[9:2];
      w_q  <= m_hwrite;
    end
  end
endmodule

// *** tb_dma_channel_list_and_stop.sv ***
// tb_dma_channel_list_and_stop.sv: self-checking bench of the dma channel
// assumes dma_mem_model as memory; all addresses word aligned, word widths only
`timescale 1ns/1ps
`include "dma_chan_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_dma_channel_list_and_stop;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, m_haddr, m_hwdata, m_hrdata;
  logic [1:0]  htrans, m_htrans;
  logic [2:0]  hsize, m_hsize;
  logic        m_hwrite, m_hready, src_req, src_ack;
  int          n_fail = 0;
  int          num_checks = 0;
  int          n_ack = 0;
  always @(posedge hclk) begin
    if (src_ack === 1'b1) n_ack <= n_ack + 1;
  end
  dma_chan u_dma_chan (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .m_haddr(m_haddr),
    .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize), .m_hwdata(m_hwdata),
    .m_hrdata(m_hrdata), .m_hready(m_hready), .src_req(src_req), .src_ack(src_ack));
  dma_mem_model u_dma_mem_model (.hclk(hclk), .slow(slow), .m_haddr(m_haddr),
    .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata),
    .m_hready(m_hready), .src_req(src_req));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    hsel   <= 1'b1;
    htrans <= `HT_NONSEQ;
    haddr  <= {20'h0, a};
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= `HT_IDLE;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin n_fail++; give_verdict(); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q & m)
  endtask
  // polls the channel status until the enable reads zero
  task automatic wait_off();
    logic [31:0] q;
    int i;
    q = 32'h1;
    for (i = 0; i < 300 && q[0] === 1'b1; i++) bus(1'b0, `OFF_CHSR, 32'h0, q);
    if (i >= 300) begin n_fail++; give_verdict(); end
  endtask
  task automatic t_reset();
    rc(`OFF_CHSR, 32'hffff_ffff, 32'h0001_0000, "chsr");
    rc(`OFF_GCFG, 32'hffff_ffff, 32'h0000_0010, "gcfg");
    rc(`OFF_CFG, 32'hffff_ffff, 32'h0100_0000, "cfg");
    rc(12'h100, 32'hffff_ffff, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_list();
    // two items: done bits cleared, last item ends the chain
    u_dma_mem_model.mem[8'h40] = 32'h0000_0200;
    u_dma_mem_model.mem[8'h41] = 32'h0000_0380;
    u_dma_mem_model.mem[8'h42] = 32'h0000_0140;
    u_dma_mem_model.mem[8'h43] = 32'h2200_0002;
    u_dma_mem_model.mem[8'h44] = 32'h0;
    u_dma_mem_model.mem[8'h50] = 32'h0000_0208;
    u_dma_mem_model.mem[8'h51] = 32'h0000_0380;
    u_dma_mem_model.mem[8'h52] = 32'h0;
    u_dma_mem_model.mem[8'h53] = 32'h2200_0001;
    u_dma_mem_model.mem[8'h54] = 32'h0;
    slow <= 1'b1;
    wr(`OFF_EN, 32'h1);
    wr(`OFF_DADDR, 32'h300);
    wr(`OFF_DSCR, 32'h100);
    wr(`OFF_CTRLA, 32'h2200_0001);
    wr(`OFF_CTRLB, 32'h0);
    wr(`OFF_CHER, 32'h1);
    wait_off();
    `CHK("dst0", 32'ha000_0080, u_dma_mem_model.mem[8'hc0])
    `CHK("dst2", 32'ha000_0082, u_dma_mem_model.mem[8'hc2])
    `CHK("item dst", 32'ha000_00e0, u_dma_mem_model.mem[8'he0])
    `CHK("done0", 1'b1, u_dma_mem_model.mem[8'h43][31])
    `CHK("done1", 1'b1, u_dma_mem_model.mem[8'h53][31])
    `CHK("next0", 32'h140, u_dma_mem_model.mem[8'h42])
    `CHK("wback size", 3'h2, m_hsize)
    rc(`OFF_STAT, 32'h3, 32'h3, "stat");
    rc(`OFF_CHSR, 32'h1, 32'h0, "chsr en");
    $display("test list done");
  endtask
  task automatic t_wprot();
    wr(`OFF_SADDR, 32'h44);
    wr(`OFF_WPMR, 32'h1);
    wr(`OFF_SADDR, 32'h55);
    rc(`OFF_WPSR, 32'hffff_ffff, 32'h0000_3c01, "wpsr");
    rc(`OFF_WPSR, 32'h1, 32'h0, "wpsr clr");
    wr(`OFF_EN, 32'h0);
    wr(`OFF_GCFG, 32'h0);
    rc(`OFF_EN, 32'h1, 32'h1, "en");
    rc(`OFF_GCFG, 32'hffff_ffff, 32'h0000_0010, "gcfg prot");
    `CHK("okay", 1'b0, hresp)
    rc(`OFF_SADDR, 32'hffff_ffff, 32'h44, "saddr");
    wr(`OFF_WPMR, 32'h0);
    $display("test wprot done");
  endtask
  task automatic t_zero();
    wr(`OFF_DSCR, 32'h0);
    wr(`OFF_CTRLA, 32'h2200_0000);
    wr(`OFF_CTRLB, 32'h0001_0000);
    wr(`OFF_SADDR, 32'h200);
    wr(`OFF_DADDR, 32'h3c0);
    wr(`OFF_CHER, 32'h1);
    wait_off();
    `CHK("zero dst", 32'ha000_00f0, u_dma_mem_model.mem[8'hf0])
    rc(`OFF_STAT, 32'h3, 32'h0, "zero stat");
    $display("test zero done");
  endtask
  task automatic t_susp();
    wr(`OFF_CTRLA, 32'h2200_0008);
    wr(`OFF_DADDR, 32'h340);
    wr(`OFF_CFG, 32'h0100_0200);
    wr(`OFF_CHER, 32'h1);
    wr(`OFF_CHER, 32'h100);
    rc(`OFF_CHSR, 32'h101, 32'h101, "susp");
    repeat (60) @(posedge hclk);
    rc(`OFF_CHSR, 32'h10101, 32'h10101, "empty");
    `CHK("held", 32'ha000_00d1, u_dma_mem_model.mem[8'hd1])
    wr(`OFF_CHDR, 32'h100);
    wait_off();
    `CHK("resumed", 32'ha000_0087, u_dma_mem_model.mem[8'hd7])
    `CHK("acks", 8, n_ack)
    $display("test suspend done");
  endtask
  task automatic t_abort();
    wr(`OFF_CTRLA, 32'h2200_0040);
    wr(`OFF_DADDR, 32'h300);
    wr(`OFF_CHER, 32'h1);
    repeat (10) @(posedge hclk);
    wr(`OFF_EN, 32'h0);
    wait_off();
    `CHK("dropped", 32'ha000_00ff, u_dma_mem_model.mem[8'hff])
    wr(`OFF_EN, 32'h1);
    rc(`OFF_CHSR, 32'h1, 32'h0, "idle");
    $display("test abort done");
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = `HT_IDLE;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    slow    = 1'b0;
    for (int i = 0; i < 256; i++) u_dma_mem_model.mem[i] = 32'ha000_0000 + i;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_list();
    t_wprot();
    t_zero();
    t_susp();
    t_abort();
    give_verdict();
  end
endmodule
